// *** design/cpx_port.sv ***
// Core end of the external coprocessor port with store-data buffering
`timescale 1ns/1ps
module cpx_port #(
    parameter int DATA_W = cpx_pkg::DATA_W,
    parameter int DEPTH = cpx_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rstn,
    // Core pipeline side
    input wire logic coreStall,
    input wire logic issueValid,
    output logic issueReady,
    input wire logic [31:0] issueInstr,
    input wire logic issuePriv,
    input wire logic issueCondPass,
    input wire logic issueIsLdst,
    input wire logic issueIsStore,
    input wire logic [3:0] issueWordCount,
    input wire logic lateCancel,
    input wire logic ldstAbort,
    input wire logic storeValid,
    output logic storeReady,
    input wire logic [DATA_W-1:0] storeData,
    output logic loadValid,
    output logic [DATA_W-1:0] loadData,
    output logic doneValid,
    output logic [1:0] doneStatus,
    // Coprocessor side
    output logic follower_advance_enable,
    output logic [31:0] cop_instruction_bus,
    output logic instr_valid_n,
    output logic instr_request_n,
    output logic privileged_access_flag,
    output logic execute_commit_flag,
    output logic late_cancel_flag,
    output logic ldst_abort_flag,
    output logic [3:0] ldst_word_count,
    output logic [DATA_W-1:0] core_to_cop_data,
    input wire logic [DATA_W-1:0] cop_to_core_data,
    input wire logic external_cop_enable,
    input wire logic [1:0] decode_handshake,
    input wire logic [1:0] execute_handshake
);
    localparam int LW = $clog2(DEPTH + 1);

    cpx_pkg::cpx_state_t stateR;
    cpx_pkg::cpx_state_t stateNxt;
    logic step;
    logic [1:0] hsDe;
    logic [1:0] hsEx;
    logic issueAccept;
    logic deGo;
    logic deAbsent;
    logic exGo;
    logic exAbsent;
    logic xferWord;
    logic lastWord;
    logic cancelNow;
    logic pop;
    logic advNxt;
    logic condPassR;
    logic isLdstR;
    logic isStoreR;
    logic [3:0] wordsLeftR;
    logic fifoValid;
    logic fifoInReady;
    logic [DATA_W-1:0] fifoData;
    logic [LW-1:0] fifoLevel;
    logic issueReady_r;
    logic storeReady_r;

    // All pipeline steps are taken on edges the follower also sees
    // shared advance edge
    assign step = follower_advance_enable;

    // disabled means absent: do not trust floating answers
    assign hsDe = external_cop_enable ? decode_handshake : cpx_pkg::HS_ABSENT;
    assign hsEx = external_cop_enable ? execute_handshake : cpx_pkg::HS_ABSENT;

    assign issueAccept = step && (stateR == cpx_pkg::ST_IDLE) && issueValid;
    assign deGo = step && (stateR == cpx_pkg::ST_DECODE) && cpx_pkg::cpx_hs_going(hsDe);
    assign deAbsent = step && (stateR == cpx_pkg::ST_DECODE) && (hsDe == cpx_pkg::HS_ABSENT);
    assign exGo = step && (stateR == cpx_pkg::ST_EXEC) && cpx_pkg::cpx_hs_going(hsEx);
    assign exAbsent = step && (stateR == cpx_pkg::ST_EXEC) && (hsEx == cpx_pkg::HS_ABSENT);
    assign cancelNow = step && (stateR == cpx_pkg::ST_XFER) && late_cancel_flag;
    assign xferWord = step && (stateR == cpx_pkg::ST_XFER) && !late_cancel_flag && isLdstR
        && (!isStoreR || fifoValid);
    assign lastWord = (wordsLeftR == cpx_pkg::WORDS_ONE);
    assign pop = xferWord && isStoreR;

    // Sequencing through decode, execute, memory and write-back
    always_comb begin
        stateNxt = stateR;
        unique case (stateR)
            cpx_pkg::ST_IDLE: begin
                if (issueAccept) begin
                    stateNxt = cpx_pkg::ST_DECODE;
                end
            end
            cpx_pkg::ST_DECODE: begin
                if (deAbsent || (deGo && !condPassR)) begin
                    stateNxt = cpx_pkg::ST_IDLE;
                end else if (deGo) begin
                    stateNxt = cpx_pkg::ST_EXEC;
                end
            end
            cpx_pkg::ST_EXEC: begin
                if (exAbsent) begin
                    stateNxt = cpx_pkg::ST_IDLE;
                end else if (exGo) begin
                    stateNxt = cpx_pkg::ST_XFER;
                end
            end
            cpx_pkg::ST_XFER: begin
                if (cancelNow) begin
                    stateNxt = cpx_pkg::ST_IDLE;
                end else if (step && (!isLdstR || (xferWord && lastWord))) begin
                    stateNxt = cpx_pkg::ST_WB;
                end
            end
            cpx_pkg::ST_WB: begin
                if (step) begin
                    stateNxt = cpx_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stateR <= cpx_pkg::ST_IDLE;
        end else begin
            stateR <= stateNxt;
        end
    end

    // Hold the enable low rather than let a store step with no word
    always_comb begin
        advNxt = !coreStall;
        if (stateNxt == cpx_pkg::ST_XFER && isStoreR && isLdstR
            && fifoLevel <= (pop ? LW'(1) : LW'(0))) begin
            advNxt = 1'b0;
        end
    end

    // every port output is a flop updated on the rising edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            follower_advance_enable <= 1'b0;
            issueReady_r <= 1'b0;
            storeReady_r <= 1'b0;
        end else begin
            follower_advance_enable <= advNxt;
            issueReady_r <= (stateNxt == cpx_pkg::ST_IDLE);
            storeReady_r <= fifoInReady;
        end
    end
    assign issueReady = issueReady_r;
    assign storeReady = storeReady_r;

    // instruction bus, its active-low valid and request
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cop_instruction_bus <= cpx_pkg::RST_WORD;
            instr_valid_n <= cpx_pkg::RST_VALID_N;
            instr_request_n <= cpx_pkg::RST_REQ_N;
        end else if (issueAccept) begin
            cop_instruction_bus <= issueInstr;
            instr_valid_n <= 1'b0;
            instr_request_n <= 1'b0;
        end else begin
            // Request is taken on one enabled edge only
            if (step) begin
                instr_request_n <= 1'b1;
            end
            if (stateNxt == cpx_pkg::ST_IDLE) begin
                instr_valid_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            privileged_access_flag <= cpx_pkg::RST_PRIV;
            condPassR <= 1'b0;
            isLdstR <= 1'b0;
            isStoreR <= 1'b0;
        end else if (issueAccept) begin
            privileged_access_flag <= issuePriv;
            condPassR <= issueCondPass;
            isLdstR <= issueIsLdst;
            isStoreR <= issueIsLdst && issueIsStore;
        end
    end

    // word count, forced to zero while no coprocessor is enabled
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ldst_word_count <= cpx_pkg::WORDS_NONE;
        end else if (!external_cop_enable) begin
            ldst_word_count <= cpx_pkg::WORDS_NONE;
        end else if (issueAccept) begin
            ldst_word_count <= issueIsLdst ? issueWordCount : cpx_pkg::WORDS_NONE;
        end
    end

    // Remaining words; a count of zero still moves one word
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wordsLeftR <= cpx_pkg::WORDS_NONE;
        end else if (issueAccept) begin
            wordsLeftR <= (issueWordCount == cpx_pkg::WORDS_NONE) ? cpx_pkg::WORDS_ONE
                : issueWordCount;
        end else if (xferWord) begin
            wordsLeftR <= wordsLeftR - 4'h1;
        end
    end

    // commit stands through Execute until the answer proceeds or is absent
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            execute_commit_flag <= 1'b0;
        end else if (deGo && condPassR) begin
            execute_commit_flag <= 1'b1;
        end else if (exGo || exAbsent) begin
            execute_commit_flag <= 1'b0;
        end
    end

    // First memory cycle carries the cancel; cancelled words never move
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            late_cancel_flag <= 1'b0;
        end else if (exGo) begin
            late_cancel_flag <= lateCancel;
        end else if (step) begin
            late_cancel_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ldst_abort_flag <= 1'b0;
        end else begin
            ldst_abort_flag <= (stateNxt == cpx_pkg::ST_WB) && isLdstR && ldstAbort
                && (stateR != cpx_pkg::ST_WB || ldst_abort_flag);
        end
    end

    // store words leave through their own output bus
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            core_to_cop_data <= '0;
        end else if (pop) begin
            core_to_cop_data <= fifoData;
        end
    end

    // load words sampled from the return bus
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            loadValid <= 1'b0;
            loadData <= '0;
        end else begin
            loadValid <= xferWord && !isStoreR;
            if (xferWord && !isStoreR) begin
                loadData <= cop_to_core_data;
            end
        end
    end

    // Completion report, one pulse per accepted instruction
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            doneValid <= 1'b0;
            doneStatus <= cpx_pkg::DONE_OK;
        end else begin
            doneValid <= deAbsent || exAbsent || (deGo && !condPassR) || cancelNow
                || (step && stateR == cpx_pkg::ST_WB);
            if (deAbsent || exAbsent) begin
                doneStatus <= cpx_pkg::DONE_ABSENT;
            end else if ((deGo && !condPassR) || cancelNow) begin
                doneStatus <= cpx_pkg::DONE_CANCEL;
            end else if (step && stateR == cpx_pkg::ST_WB) begin
                doneStatus <= ldst_abort_flag ? cpx_pkg::DONE_ABORT : cpx_pkg::DONE_OK;
            end
        end
    end

    // Store buffer; the core is stalled through storeReady one cycle after it fills, so one offer is refused
    cpx_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH),
        .LW(LW)
    ) u_store_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .inValid(storeValid),
        .inReady(fifoInReady),
        .inData(storeData),
        .outValid(fifoValid),
        .outReady(pop),
        .outData(fifoData),
        .level(fifoLevel)
    );

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence seqDecodeGo;
        deGo && condPassR;
    endsequence
    sequence seqIssue;
        issueAccept ##1 !instr_request_n;
    endsequence

    a_abort_in_wb: assert property (ldst_abort_flag |-> stateR == cpx_pkg::ST_WB)
        else $error("abort flag outside write-back");
    a_count_when_off: assert property (!external_cop_enable |=> ldst_word_count == 4'h0)
        else $error("word count not zero while disabled");
    a_store_word_out: assert property (pop |=> core_to_cop_data == $past(fifoData))
        else $error("store word not presented");
    a_instr_bus_valid: assert property (seqIssue |-> !instr_valid_n
        && cop_instruction_bus == $past(issueInstr))
        else $error("instruction bus not loaded on request");
    a_request_one_step: assert property (!instr_request_n && step |=> instr_request_n)
        else $error("request held over an enabled edge");
    a_commit_on_go: assert property (seqDecodeGo |=> execute_commit_flag
        ##0 stateR == cpx_pkg::ST_EXEC)
        else $error("commit not raised after go");
    a_absent_reports: assert property (deAbsent |=> doneValid
        && doneStatus == cpx_pkg::DONE_ABSENT ##1 !doneValid)
        else $error("absent answer not reported once");
    a_priv_follows: assert property (issueAccept |=> privileged_access_flag == $past(issuePriv))
        else $error("privilege flag not taken from issue");
    a_stall_edge: assert property (coreStall |=> !follower_advance_enable)
        else $error("advance enable high after stall");
endmodule : cpx_port

// *** include/cpx_pkg.sv ***
// Constants, types and decode helpers for the coprocessor port block
// Function
// - Abort flag for aborted load/store, in write-back
// - Four-bit word count; zero without coprocessor
// - Core sends data on separate 32-bit bus
// - Instructions go out on 32-bit bus
// - Commit flag marks Execute instruction; coprocessor executes
// - Decode handshake: 10 absent, 00 wait, 01 go, 11 last
// - Active-low valid qualifies the instruction bus
// - Privilege flag low nonprivileged, high privileged
// - Outputs change after, inputs sampled on, rising edge
package cpx_pkg;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 4;
    localparam int FIFO_DEPTH = 16;

    // Handshake encoding shared by the decode and execute answers
    localparam logic [1:0] HS_ABSENT = 2'h2;
    localparam logic [1:0] HS_WAIT = 2'h0;
    localparam logic [1:0] HS_GO = 2'h1;
    localparam logic [1:0] HS_LAST = 2'h3;

    // Word counts: none, driven when no coprocessor takes part, and one
    localparam logic [3:0] WORDS_NONE = 4'h0;
    localparam logic [3:0] WORDS_ONE = 4'h1;

    // Completion codes reported to the core
    localparam logic [1:0] DONE_OK = 2'h0;
    localparam logic [1:0] DONE_ABSENT = 2'h1;
    localparam logic [1:0] DONE_CANCEL = 2'h2;
    localparam logic [1:0] DONE_ABORT = 2'h3;

    // Values after reset
    localparam logic RST_REQ_N = 1'b1;
    localparam logic RST_VALID_N = 1'b1;
    localparam logic RST_PRIV = 1'b0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_EXEC,
        ST_XFER,
        ST_WB
    } cpx_state_t;

    // True for an answer that lets the instruction proceed
    function automatic logic cpx_hs_going(input logic [1:0] hs);
        return (hs == HS_GO) || (hs == HS_LAST);
    endfunction : cpx_hs_going
endpackage : cpx_pkg

// *** design/cpx_fifo.sv ***
// Store-data FIFO with registered full and empty flags
`timescale 1ns/1ps
module cpx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    parameter int LW = $clog2(DEPTH + 1)
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [LW-1:0] level
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_r;
    logic [PW-1:0] rdPtr_r;
    logic [LW-1:0] cnt_r;
    logic [LW-1:0] cnt_nxt;
    logic full_r;
    logic empty_r;
    logic push;
    logic pop;

    // Flags are registered so the core-facing ready is a flop
    assign push = inValid && !full_r;
    assign pop = outReady && !empty_r;
    assign inReady = !full_r;
    assign outValid = !empty_r;
    assign outData = mem[rdPtr_r];
    assign level = cnt_r;

    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + LW'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - LW'(1);
        end
    end

    // Storage needs no reset; only valid words are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // Pointers wrap naturally for a power-of-two depth
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            cnt_r <= '0;
            full_r <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + PW'(1);
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + PW'(1);
            end
            cnt_r <= cnt_nxt;
            full_r <= (cnt_nxt == LW'(DEPTH));
            empty_r <= (cnt_nxt == '0);
        end
    end
endmodule : cpx_fifo

// *** tb/cpx_cop_model.sv ***
// Behavioural pipeline follower standing at the far side of the port
`timescale 1ns/1ps
module cpx_cop_model (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic copEn,
    input wire logic [1:0] answer,
    input wire logic [3:0] waitCycles,
    input wire logic follower_advance_enable,
    input wire logic instr_request_n,
    output logic [31:0] cop_to_core_data,
    output logic [1:0] decode_handshake,
    output logic [1:0] execute_handshake
);
    logic [3:0] waitCnt_r;
    logic [15:0] seq_r;
    logic [1:0] hs;

    // absent when disabled, else wait then answer
    assign hs = !copEn ? cpx_pkg::HS_ABSENT :
        (waitCnt_r < waitCycles) ? cpx_pkg::HS_WAIT : answer;
    assign decode_handshake = hs;
    assign execute_handshake = hs;
    // read word changes on every advance, so stale data never matches
    assign cop_to_core_data = {16'hc0de, seq_r};

    // stages move on enabled edges only
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            waitCnt_r <= 4'h0;
            seq_r <= 16'h0;
        end else if (follower_advance_enable) begin
            seq_r <= seq_r + 16'h1;
            if (!instr_request_n || hs != cpx_pkg::HS_WAIT) begin
                waitCnt_r <= 4'h0; // Each stage waits afresh
            end else begin
                waitCnt_r <= waitCnt_r + 4'h1;
            end
        end
    end
endmodule : cpx_cop_model

// *** tb/cpx_port_test.sv ***
// Self-checking bench for the coprocessor port
`timescale 1ns/1ps
module cpx_port_test;
    logic sys_clk, rstn, coreStall, issueValid, issueReady, issuePriv, issueCondPass;
    logic issueIsLdst, issueIsStore, lateCancel, ldstAbort, storeValid, storeReady;
    logic loadValid, doneValid, follower_advance_enable, instr_valid_n, instr_request_n;
    logic privileged_access_flag, execute_commit_flag, late_cancel_flag, ldst_abort_flag;
    logic copEn, commitSeen, abortSeen, busBad, chop, lcSeen;
    logic [31:0] issueInstr, storeData, loadData, cop_instruction_bus, core_to_cop_data;
    logic [31:0] cop_to_core_data;
    logic [3:0] issueWordCount, ldst_word_count, waitCycles, wcSeen;
    logic [1:0] doneStatus, decode_handshake, execute_handshake, answer, st;
    logic [31:0] seen[$];
    int errors, checked, loadCnt;

    cpx_port dut_u (.sys_clk(sys_clk), .rstn(rstn), .coreStall(coreStall),
        .issueValid(issueValid), .issueReady(issueReady), .issueInstr(issueInstr),
        .issuePriv(issuePriv), .issueCondPass(issueCondPass), .issueIsLdst(issueIsLdst),
        .issueIsStore(issueIsStore), .issueWordCount(issueWordCount),
        .lateCancel(lateCancel), .ldstAbort(ldstAbort), .storeValid(storeValid),
        .storeReady(storeReady), .storeData(storeData), .loadValid(loadValid),
        .loadData(loadData), .doneValid(doneValid), .doneStatus(doneStatus),
        .follower_advance_enable(follower_advance_enable),
        .cop_instruction_bus(cop_instruction_bus), .instr_valid_n(instr_valid_n),
        .instr_request_n(instr_request_n), .privileged_access_flag(privileged_access_flag),
        .execute_commit_flag(execute_commit_flag), .late_cancel_flag(late_cancel_flag),
        .ldst_abort_flag(ldst_abort_flag), .ldst_word_count(ldst_word_count),
        .core_to_cop_data(core_to_cop_data), .cop_to_core_data(cop_to_core_data),
        .external_cop_enable(copEn), .decode_handshake(decode_handshake),
        .execute_handshake(execute_handshake));

    cpx_cop_model cop_u (.sys_clk(sys_clk), .rstn(rstn), .copEn(copEn), .answer(answer),
        .waitCycles(waitCycles), .follower_advance_enable(follower_advance_enable),
        .instr_request_n(instr_request_n), .cop_to_core_data(cop_to_core_data),
        .decode_handshake(decode_handshake), .execute_handshake(execute_handshake));

    // Clock at 25 MHz
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    // inputs after edge
    // Inputs always move 1 ns after the rising edge
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic stuck();
        errors++;
        $display("mismatch at %0t: wait ran out", $time);
        close_out();
    endtask : stuck

    // Issue one instruction and watch the link until done; flags = priv,pass,ldst,store
    task automatic run(input logic [31:0] ins, input logic [3:0] flags, input logic [3:0] wc);
        int n;
        logic [31:0] last;
        {issuePriv, issueCondPass, issueIsLdst, issueIsStore} = flags;
        issueInstr = ins;
        issueWordCount = wc;
        issueValid = 1'b1;
        n = 0;
        while (!(issueReady === 1'b1 && follower_advance_enable === 1'b1)) begin
            tick();
            n++;
            if (n > 50) stuck();
        end
        tick();
        issueValid = 1'b0;
        wcSeen = ldst_word_count;
        last = core_to_cop_data;
        seen.delete();
        {commitSeen, abortSeen, busBad, lcSeen} = 4'h0;
        loadCnt = 0;
        n = 0;
        while (doneValid !== 1'b1) begin
            if (instr_valid_n !== 1'b0 || cop_instruction_bus !== ins) busBad = 1'b1;
            if (privileged_access_flag !== flags[3]) busBad = 1'b1;
            commitSeen |= execute_commit_flag;
            abortSeen |= ldst_abort_flag;
            lcSeen |= late_cancel_flag;
            if (loadValid === 1'b1) begin
                loadCnt++;
                check(loadData[31:16], 32'h0000_c0de, "load word");
            end
            if (core_to_cop_data !== last) seen.push_back(core_to_cop_data);
            last = core_to_cop_data;
            if (chop) coreStall = n[0]; // Follower stalls on alternate cycles
            tick();
            n++;
            if (n > 300) stuck();
        end
        st = doneStatus;
        tick();
    endtask : run

    task automatic t_plain();
        for (int i = 0; i < 2; i++) begin
            answer = i[0] ? cpx_pkg::HS_LAST : cpx_pkg::HS_GO;
            waitCycles = i[0] ? 4'h3 : 4'h0;
            run(32'hee00_1a10 + i, {i[0], 3'h4}, 4'h0);
            check(st, cpx_pkg::DONE_OK, "go answer");
            check(commitSeen, 1'b1, "commit");
            check(busBad, 1'b0, "bus and privilege");
        end
        waitCycles = 4'h0;
        $display("plain done");
    endtask : t_plain

    task automatic t_absent();
        answer = cpx_pkg::HS_ABSENT;
        run(32'hee00_2000, 4'h4, 4'h0);
        check(st, cpx_pkg::DONE_ABSENT, "absent answer");
        answer = cpx_pkg::HS_GO;
        copEn = 1'b0;
        run(32'hec00_2001, 4'h6, 4'h4);
        check(st, cpx_pkg::DONE_ABSENT, "disabled port");
        check(wcSeen, cpx_pkg::WORDS_NONE, "count when disabled");
        copEn = 1'b1;
        $display("absent done");
    endtask : t_absent

    task automatic t_cancel();
        lateCancel = 1'b1;
        run(32'hec00_3000, 4'h6, 4'h2);
        check(st, cpx_pkg::DONE_CANCEL, "late cancel");
        check(loadCnt, 0, "no words after cancel");
        check(lcSeen, 1'b1, "cancel flag shown");
        lateCancel = 1'b0;
        run(32'hee00_3001, 4'h0, 4'h0);
        check(st, cpx_pkg::DONE_CANCEL, "condition fail");
        check(commitSeen, 1'b0, "no commit");
        $display("cancel done");
    endtask : t_cancel

    task automatic t_load();
        ldstAbort = 1'b1;
        run(32'hec10_4000, 4'h6, 4'h1);
        check(st, cpx_pkg::DONE_ABORT, "abort status");
        check(abortSeen, 1'b1, "abort flag");
        ldstAbort = 1'b0;
        run(32'hec10_4001, 4'he, 4'h3);
        check({abortSeen, st}, {1'b0, cpx_pkg::DONE_OK}, "clean load");
        check(loadCnt, 3, "load words");
        check(wcSeen, 4'h3, "word count");
        $display("load done");
    endtask : t_load

    // Fill the buffer until refused, then drain it through two stores, the first under stalls
    task automatic t_store();
        int k;
        int g;
        k = 0;
        g = 0;
        storeValid = 1'b1;
        storeData = 32'h5a00_0000;
        while (storeReady === 1'b1 || k == 0) begin
            if (storeReady === 1'b1) k++;
            tick();
            g++;
            storeData = 32'h5a00_0000 + k;
            if (g > 20) stuck();
        end
        storeValid = 1'b0;
        // Ready is registered, so one refused offer follows the sixteenth word
        check(k, cpx_pkg::FIFO_DEPTH + 1, "buffer depth");
        chop = 1'b1;
        run(32'hec00_5000, 4'h7, 4'hf);
        check(wcSeen, 4'hf, "store count");
        check(seen.size(), 15, "store words");
        foreach (seen[i]) check(seen[i], 32'h5a00_0000 + i, "store data");
        chop = 1'b0;
        coreStall = 1'b0;
        run(32'hec00_5001, 4'h7, 4'h0);
        check(seen.size(), 1, "single word");
        if (seen.size() > 0) check(seen[0], 32'h5a00_000f, "last word");
        $display("store done");
    endtask : t_store

    task automatic t_stall();
        logic reqSeen;
        reqSeen = 1'b0;
        coreStall = 1'b1;
        // Offer only once the enable is already low, else it is taken at once
        tick();
        issueValid = 1'b1;
        repeat (6) begin
            tick();
            reqSeen |= !instr_request_n;
            check(follower_advance_enable, 1'b0, "stalled enable");
        end
        check(reqSeen, 1'b0, "no request while stalled");
        coreStall = 1'b0;
        run(32'hee00_6000, 4'h4, 4'h0);
        check(st, cpx_pkg::DONE_OK, "after stall");
        $display("stall done");
    endtask : t_stall

    initial begin
        {rstn, coreStall, issueValid, issuePriv, issueCondPass, issueIsLdst} = 6'h0;
        {issueIsStore, lateCancel, ldstAbort, storeValid, chop} = 5'h0;
        {issueInstr, storeData, issueWordCount, waitCycles} = 72'h0;
        copEn = 1'b1;
        answer = cpx_pkg::HS_GO;
        errors = 0;
        checked = 0;
        tick();
        check({instr_valid_n, instr_request_n, privileged_access_flag}, 3'h6, "reset flags");
        check(ldst_word_count, cpx_pkg::WORDS_NONE, "reset count");
        @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        t_plain();
        t_absent();
        t_cancel();
        t_load();
        t_store();
        t_stall();
        close_out();
    end
endmodule : cpx_port_test
